/* pirf_consts.vh */
// Register map, field positions and reset values of the peripheral flag block
`ifndef PIRF_CONSTS_VH
`define PIRF_CONSTS_VH
`define PIRF_ADDR_W 4
`define PIRF_OFS_FLAGS 4'h0
`define PIRF_OFS_MASK 4'h1
`define PIRF_OFS_CTRL 4'h2
`define PIRF_OFS_SRC 4'h3
`define PIRF_BIT_TIMER_A 0
`define PIRF_BIT_TIMER_B 1
`define PIRF_BIT_CAPCMP 2
`define PIRF_BIT_SYNC 3
`define PIRF_BIT_TX 4
`define PIRF_BIT_RX 5
`define PIRF_BIT_CONV 6
`define PIRF_BIT_PAR 7
`define PIRF_STICKY_MASK 8'h4F
`define PIRF_RST_FLAGS 8'h00
`define PIRF_RST_MASK 8'h00
`define PIRF_RST_CTRL 8'h00
`define PIRF_CCMODE_CAPTURE 2'h0
`define PIRF_CCMODE_COMPARE 2'h1
`define PIRF_CCMODE_PWM 2'h2
`define PIRF_CTRL_MODE_LSB 0
`define PIRF_CTRL_MODE_MSB 1
`endif

/* pirf_sync2.v */
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ns
module pirf_sync2 (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Level in and out
   input wire d,
   output reg q
);
   reg meta;

   // First stage feeds only the second
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

/* pirf_sticky_bit.v */
// One sticky flag: hardware set, software write-zero clear, set wins
`timescale 1ns/1ns
module pirf_sticky_bit (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Set and clear requests
   input wire set,
   input wire clr,
   // Flag state
   output reg flag
);
   // Set beats a coincident clear so no event is lost
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end
endmodule

/* pirf_flags.v */
// Peripheral interrupt flag register 1 with mask, mode control and level interrupt
`timescale 1ns/1ns
`include "pirf_consts.vh"
module pirf_flags (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   // Event strobes from peripherals, same clock
   input wire conv_done,
   input wire sync_done,
   input wire capture_event,
   input wire compare_match,
   input wire timer_b_match,
   input wire timer_a_overflow,
   // Holding buffer levels, from pins of other logic domains
   input wire rx_buf_full_pin,
   input wire tx_buf_empty_pin,
   // Interrupt output
   output reg irq
);
   wire rx_full;
   wire tx_empty;
   wire [7:0] sticky;
   wire [7:0] hw_set;
   wire flag_wr;
   wire [1:0] cc_mode;
   reg [7:0] mask;
   reg [7:0] ctrl;
   reg serial_rx_flag;
   reg serial_tx_flag;
   reg [7:0] peripheral_irq_flags_1;
   reg [7:0] next_rdata;
   // Per-flag sticky state
   wire conv_done_flag;
   wire sync_serial_flag;
   wire capcmp_flag;
   wire timer_b_match_flag;
   wire timer_a_overflow_flag;
   // Per-flag clear requests
   wire conv_clr;
   wire sync_clr;
   wire capcmp_clr;
   wire timer_b_clr;
   wire timer_a_clr;
   // Capture/compare qualified events
   wire capture_hit;
   wire compare_hit;
   // Masked pending view
   wire [7:0] pending;
   wire next_irq;

   // Buffer levels cross in through two flops each
   pirf_sync2 u_rx_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d(rx_buf_full_pin),
      .q(rx_full)
   );
   pirf_sync2 u_tx_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d(tx_buf_empty_pin),
      .q(tx_empty)
   );

   assign flag_wr = wr && (addr == `PIRF_OFS_FLAGS);
   assign cc_mode = ctrl[`PIRF_CTRL_MODE_MSB:`PIRF_CTRL_MODE_LSB];

   // Set sources; no enable gates them so software may poll
   assign hw_set[`PIRF_BIT_CONV] = conv_done;
   assign hw_set[`PIRF_BIT_SYNC] = sync_done;
   assign capture_hit = capture_event && (cc_mode == `PIRF_CCMODE_CAPTURE);
   assign compare_hit = compare_match && (cc_mode == `PIRF_CCMODE_COMPARE);
   // Pulse-width and spare modes match neither term, so the flag rests
   assign hw_set[`PIRF_BIT_CAPCMP] = capture_hit || compare_hit;
   assign hw_set[`PIRF_BIT_TIMER_B] = timer_b_match;
   assign hw_set[`PIRF_BIT_TIMER_A] = timer_a_overflow;
   assign hw_set[`PIRF_BIT_TX] = 1'b0;
   assign hw_set[`PIRF_BIT_RX] = 1'b0;
   assign hw_set[`PIRF_BIT_PAR] = 1'b0;

   // A written zero clears; a written one leaves the flag alone
   assign conv_clr = flag_wr && !wdata[`PIRF_BIT_CONV];
   assign sync_clr = flag_wr && !wdata[`PIRF_BIT_SYNC];
   assign capcmp_clr = flag_wr && !wdata[`PIRF_BIT_CAPCMP];
   assign timer_b_clr = flag_wr && !wdata[`PIRF_BIT_TIMER_B];
   assign timer_a_clr = flag_wr && !wdata[`PIRF_BIT_TIMER_A];

   // Conversion-done cell
   pirf_sticky_bit u_conv_bit (
      .clk(clk),
      .reset_n(reset_n),
      .set(hw_set[`PIRF_BIT_CONV]),
      .clr(conv_clr),
      .flag(conv_done_flag)
   );

   // Synchronous serial completion cell
   pirf_sticky_bit u_sync_bit (
      .clk(clk),
      .reset_n(reset_n),
      .set(hw_set[`PIRF_BIT_SYNC]),
      .clr(sync_clr),
      .flag(sync_serial_flag)
   );

   // Capture/compare cell; mode gating happens at its set input
   pirf_sticky_bit u_capcmp_bit (
      .clk(clk),
      .reset_n(reset_n),
      .set(hw_set[`PIRF_BIT_CAPCMP]),
      .clr(capcmp_clr),
      .flag(capcmp_flag)
   );

   // Timer B period match cell
   pirf_sticky_bit u_timer_b_bit (
      .clk(clk),
      .reset_n(reset_n),
      .set(hw_set[`PIRF_BIT_TIMER_B]),
      .clr(timer_b_clr),
      .flag(timer_b_match_flag)
   );

   // Timer A overflow cell
   pirf_sticky_bit u_timer_a_bit (
      .clk(clk),
      .reset_n(reset_n),
      .set(hw_set[`PIRF_BIT_TIMER_A]),
      .clr(timer_a_clr),
      .flag(timer_a_overflow_flag)
   );

   // Sticky lanes gathered; buffer lanes and the top bit are zero here
   assign sticky = {1'b0, conv_done_flag, 2'b00, sync_serial_flag, capcmp_flag,
      timer_b_match_flag, timer_a_overflow_flag};

   // Buffer-state flags follow the level; software cannot write them
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_rx_flag <= 1'b0;
         serial_tx_flag <= 1'b0;
      end else begin
         serial_rx_flag <= rx_full;
         serial_tx_flag <= tx_empty;
      end
   end

   // Assembled flag view
   always @* begin
      peripheral_irq_flags_1 = sticky;
      peripheral_irq_flags_1[`PIRF_BIT_RX] = serial_rx_flag;
      peripheral_irq_flags_1[`PIRF_BIT_TX] = serial_tx_flag;
   end

   // Mask and mode registers
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask <= `PIRF_RST_MASK;
         ctrl <= `PIRF_RST_CTRL;
      end else if (wr) begin
         if (addr == `PIRF_OFS_MASK) begin
            mask <= wdata;
         end
         if (addr == `PIRF_OFS_CTRL) begin
            ctrl <= {6'h00, wdata[1:0]};
         end
      end
   end

   // Masked view shared by the source read and the interrupt line
   assign pending = peripheral_irq_flags_1 & mask;
   assign next_irq = |pending;

   // Read mux; unmapped addresses read zero
   always @* begin
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            `PIRF_OFS_FLAGS: next_rdata = peripheral_irq_flags_1;
            `PIRF_OFS_MASK: next_rdata = mask;
            `PIRF_OFS_CTRL: next_rdata = ctrl;
            `PIRF_OFS_SRC: next_rdata = pending;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Registered outputs; mask gates the line and the source read, never the flags
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
         irq <= 1'b0;
      end else begin
         rdata <= next_rdata;
         irq <= next_irq;
      end
   end
endmodule

/* pirf_serial_model.sv */
// Serial unit model driving the holding buffer levels
`timescale 1ns/1ns
module pirf_serial_model (
   // Clock and reset
   input wire clk, reset_n,
   // Line side and software side buffer traffic
   input wire rx_arrive, rx_take, tx_load, tx_send,
   // Levels toward the flag block
   output reg rx_full, tx_empty
);
   // Levels move only on buffer traffic
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_full <= 1'h0;
         tx_empty <= 1'h1;
      end else begin
         rx_full <= rx_arrive | (rx_full & ~rx_take);
         tx_empty <= tx_send | (tx_empty & ~tx_load);
      end
   end
endmodule

/* pirf_flags_checker.sv */
// Port timing checks of the flag block
`timescale 1ns/1ns
module pirf_flags_checker (
   // Clock, reset, register port
   input wire clk, reset_n, wr, rd,
   input wire [3:0] addr,
   input wire [7:0] wdata, rdata,
   // Events, levels, interrupt
   input wire conv_done, sync_done, capture_event, compare_match, timer_b_match,
   input wire timer_a_overflow, rx_buf_full_pin, tx_buf_empty_pin, irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Flag register read
   wire rf = rd && addr == 4'h0;
   // Event, one quiet cycle with no write, then a flag read
   a_conv_sticky: assert property (conv_done ##1 !wr ##1 rf |=> rdata[6]) else $error("conv");
   a_sync_sticky: assert property (sync_done ##1 !wr ##1 rf |=> rdata[3]) else $error("sync");
   a_match_sticky: assert property (timer_b_match ##1 !wr ##1 rf |=> rdata[1]) else $error("tb");
   a_ovf_sticky: assert property (timer_a_overflow ##1 !wr ##1 rf |=> rdata[0]) else $error("ta");
   a_rx_level: assert property ($stable(rx_buf_full_pin)[*5] ##0 rf |=>
      rdata[5] == $past(rx_buf_full_pin)) else $error("rx");
   a_tx_level: assert property ($stable(tx_buf_empty_pin)[*5] ##0 rf |=>
      rdata[4] == $past(tx_buf_empty_pin)) else $error("tx");
   a_zero_clears: assert property (wr && addr == 4'h0 && !wdata[6] && !conv_done ##1 !conv_done
      ##1 rf |=> !rdata[6]) else $error("clear");
   a_irq_follows: assert property (rd && addr == 4'h3 |=> irq == (rdata != 8'h00))
      else $error("irq");
   c_conv: cover property (conv_done ##2 rf);
   c_irq: cover property ($rose(irq));
   c_clear: cover property (wr && addr == 4'h0);
endmodule
bind pirf_flags pirf_flags_checker chk_u (.*);

/* pirf_flags_tb_top.sv */
// Self-checking bench of the flag block
`timescale 1ns/1ns
`include "pirf_consts.vh"
module pirf_flags_tb_top;
   reg clk = 1'h0, reset_n = 1'h0, wr = 1'h0, rd = 1'h0;
   reg [3:0] addr = 4'h0, sw = 4'h0; // sw: rx arrive, rx take, tx load, tx send
   reg [7:0] wdata = 8'h00;
   reg [5:0] ev = 6'h00; // conv, sync, capture, compare, timer B, timer A
   wire [7:0] rdata;
   wire irq, rx_full, tx_empty;
   integer failures = 0, tests_run = 0, cyc = 0, i;
   localparam [3:0] fr = `PIRF_OFS_FLAGS;
   localparam [47:0] bits = {8'h40, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01};
   pirf_flags dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .conv_done(ev[5]), .sync_done(ev[4]), .capture_event(ev[3]),
      .compare_match(ev[2]), .timer_b_match(ev[1]), .timer_a_overflow(ev[0]),
      .rx_buf_full_pin(rx_full), .tx_buf_empty_pin(tx_empty), .irq(irq));
   pirf_serial_model sp_u (.clk(clk), .reset_n(reset_n), .rx_arrive(sw[3]), .rx_take(sw[2]),
      .tx_load(sw[1]), .tx_send(sw[0]), .rx_full(rx_full), .tx_empty(tx_empty));
   initial forever #25 clk = ~clk;
   task chk(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   // Write cycle; events ride along so they can meet a write
   task wreg(input [3:0] a, input [7:0] d, input [5:0] e);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1'h1;
         ev <= e;
         @(posedge clk);
         wr <= 1'h0;
         ev <= 6'h00;
         @(posedge clk);
      end
   endtask
   task rreg(input [3:0] a, input [7:0] e);
      begin
         addr <= a;
         rd <= 1'h1;
         @(posedge clk);
         rd <= 1'h0;
         @(negedge clk) chk(rdata, e);
         @(posedge clk);
      end
   endtask
   // Buffer traffic, then time for the level to cross the synchroniser
   task serial(input [3:0] s);
      begin
         sw <= s;
         @(posedge clk);
         sw <= 4'h0;
         repeat (5) @(posedge clk);
      end
   endtask
   task tally_and_finish;
      begin
         $display("failures %0d tests_run %0d", failures, tests_run);
         if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         failures = failures + 1;
         tally_and_finish;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      repeat (5) @(posedge clk);
      rreg(fr, 8'h10);
      rreg(`PIRF_OFS_MASK, `PIRF_RST_MASK);
      rreg(`PIRF_OFS_CTRL, `PIRF_RST_CTRL);
      for (i = 0; i < 6; i = i + 1) begin
         wreg(`PIRF_OFS_CTRL, {7'h00, i == 2}, 6'h00);
         wreg(4'hF, 8'h00, 6'h01 << i);
         rreg(fr, 8'h10 | bits[i*8 +: 8]);
         wreg(fr, 8'hFF, 6'h00);
         rreg(fr, 8'h10 | bits[i*8 +: 8]);
         wreg(fr, ~bits[i*8 +: 8], 6'h00);
         rreg(fr, 8'h10);
      end
      rreg(4'hF, 8'h00);
      wreg(`PIRF_OFS_CTRL, {6'h00, `PIRF_CCMODE_PWM}, 6'h00);
      wreg(4'hF, 8'h00, 6'h0C);
      rreg(fr, 8'h10);
      wreg(fr, 8'h00, 6'h20);
      rreg(fr, 8'h50);
      wreg(`PIRF_OFS_MASK, 8'h40, 6'h00);
      rreg(`PIRF_OFS_SRC, 8'h40);
      chk({7'h00, irq}, 8'h01);
      wreg(fr, 8'h00, 6'h00);
      rreg(`PIRF_OFS_SRC, 8'h00);
      chk({7'h00, irq}, 8'h00);
      serial(4'h8);
      rreg(fr, 8'h30);
      serial(4'h6);
      rreg(fr, 8'h00);
      serial(4'h1);
      rreg(fr, 8'h10);
      tally_and_finish;
   end
endmodule
